// ===== fcs_array_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.svh"
// Flash array model: word memory with registered read
module fcs_array_mem
(
  input  wire logic i_ref_clk,
  fcs_mem_if.mem    mem
);
  import fcs_pkg::*;
  logic [15:0] store_reg [0:(1<<`FCS_ADDR_W)-1]; // Cell contents

  // Write port; erase is done word by word by the sequencer
  always_ff @(posedge i_ref_clk)
  begin
    if (mem.we)
    begin
      store_reg[mem.waddr] <= mem.wdata;
    end
  end

  // Read data leave from a register
  always_ff @(posedge i_ref_clk)
  begin
    mem.rdata <= store_reg[mem.raddr];
  end
endmodule // fcs_array_mem
`default_nettype wire

// ===== fcs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// CPU side: single-cycle strobes, then released lines
module fcs_cpu_model
(
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ready,
  output logic      [12:0] o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial
  begin
    o_addr = 13'h0000;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One access; idle lines flip so stale values never look valid
  task automatic xfer(input logic w, input logic [12:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    o_addr <= {a[12:1], 1'b0};
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
  endtask
  task automatic put(input logic [12:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  // Read data is taken once the answering edge has settled
  task automatic get(input logic [12:0] a, output logic [15:0] d);
    xfer(1'b0, a, 16'h0000);
    #1 d = i_rdata;
  endtask
  // Nothing else goes out until ready returns or 5000 cycles pass
  task automatic wait_ready(output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 5000 && !ok; n++)
    begin
      @(posedge i_ref_clk);
      ok = (i_ready === 1'b1);
    end
  endtask
  // Fresh page: 128 words at even offsets 00 to fe
  task automatic page(input logic [12:0] base);
    int i;
    put(base, 16'h0041);
    for (i = 0; i < 128; i++)
      put({base[12:8], 8'(i * 2)}, {8'(i + 1), 8'h00});
  endtask
endmodule // fcs_cpu_model
`default_nettype wire

// ===== fcs_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.svh"
// Flash command sequencer with block lock
module fcs_flash_seq
(
  input  wire logic        i_ref_clk,       // System clock
  input  wire logic        i_srst,          // System reset
  input  wire logic        i_flash_reset,   // Flash reset control bit
  input  wire logic        i_lock_override, // Lock override setting
  input  wire logic [12:0] i_addr,          // Byte address in user array
  input  wire logic [15:0] i_wdata,         // Write data
  input  wire logic        i_wr,            // Write strobe
  input  wire logic        i_rd,            // Read strobe
  output logic      [15:0] o_rdata,         // Read data, cycle after strobe
  output logic      [7:0]  o_status,        // Status readback value
  output logic             o_ready_busy_flag // Control register ready flag
);
  import fcs_pkg::*;

  fcs_mem_if mif();
  fcs_array_mem u_mem (.i_ref_clk(i_ref_clk), .mem(mif));

  fcs_state_t     state_reg;      // Sequencer phase
  fcs_read_mode_t rmode_reg;      // Read source
  fcs_pend_t      pend_reg;       // Awaiting confirm
  logic           ready_reg;      // Engine ready bit
  logic           efail_reg;      // Erase failure bit
  logic           pfail_reg;      // Program failure bit
  logic           ovp_reg;        // Over-programming bit
  logic [`FCS_NUM_BLOCKS-1:0] lock_reg; // Lock bits, 1 means unlocked
  logic [15:0]    page_reg [0:127]; // Page buffer
  logic [7:0]     pcnt_reg;       // Words loaded
  logic [3:0]     pblk_reg;       // Target page block
  logic [11:0]    pbase_reg;      // Page word base
  logic [15:0]    tcnt_reg;       // Operation progress count
  logic [3:0]     eblk_reg;       // Block being erased
  logic           eall_reg;       // Erase all in progress
  logic           rd_d_reg;       // Read pending
  logic           clr;            // Flash-level reset
  logic           cmd_ok;         // Write accepted while ready
  logic [7:0]     cmd;            // Low data byte
  logic [11:0]    waddr;          // Word address of access
  logic [2:0]     ablk;           // Block of access
  logic           err_any;        // Error bits block new work
  logic           blk_locked;     // Lock in force on addressed block
  logic           eblk_go;        // Current erase block allowed

  // Flash reset clears the sequencer but never the lock bits
  assign clr        = i_srst | i_flash_reset;
  assign cmd        = i_wdata[7:0]; // RULE1
  assign waddr      = i_addr[12:1];
  assign ablk       = waddr[11:9];
  assign cmd_ok     = i_wr & ready_reg; // RULE7
  assign err_any    = efail_reg | pfail_reg | ovp_reg;
  assign blk_locked = ~lock_reg[ablk] & ~i_lock_override; // RULE16
  assign eblk_go    = lock_reg[eblk_reg[2:0]] | i_lock_override; // RULE13

  // Array port: reads follow the bus, writes come from erase and program
  always_comb
  begin
    mif.raddr = waddr;
    mif.we    = 1'b0;
    mif.waddr = pbase_reg + {4'h0, tcnt_reg[7:0]};
    mif.wdata = page_reg[tcnt_reg[6:0]];
    if (state_reg == FCS_PROG && tcnt_reg < 16'(`FCS_PAGE_WORDS))
    begin
      mif.we = 1'b1; // RULE20
    end
    else if (state_reg == FCS_ERASE && eblk_go && tcnt_reg < 16'(`FCS_BLOCK_WORDS))
    begin
      mif.we    = 1'b1;
      mif.waddr = {eblk_reg[2:0], tcnt_reg[8:0]};
      mif.wdata = 16'hffff;
    end
  end

  // Page buffer load; full word is kept for data cycles
  always_ff @(posedge i_ref_clk)
  begin
    if (state_reg == FCS_LOAD_PAGE && i_wr)
    begin
      page_reg[waddr[6:0]] <= i_wdata; // RULE1
    end
  end

  // Command decoding and engine sequencing
  always_ff @(posedge i_ref_clk)
  begin
    if (clr)
    begin
      state_reg <= FCS_IDLE;
      rmode_reg <= FCS_RD_ARRAY; // RULE11
      pend_reg  <= FCS_PEND_ERASE;
      ready_reg <= 1'b1;
      efail_reg <= 1'b0;
      pfail_reg <= 1'b0;
      ovp_reg   <= 1'b0;
      pcnt_reg  <= 8'h00;
      pblk_reg  <= 4'h0;
      pbase_reg <= 12'h000;
      tcnt_reg  <= 16'h0000;
      eblk_reg  <= 4'h0;
      eall_reg  <= 1'b0;
      // Lock bits are nonvolatile: only the system reset starts them unlocked
      if (i_srst)
      begin
        lock_reg <= '1;
      end
    end
    else
    begin
      unique case (state_reg)
        // First cycle: new commands only while the engine is ready
        FCS_IDLE:
        begin
          if (cmd_ok)
          begin
            unique case (cmd)
              `FCS_CMD_READ_ARRAY:  rmode_reg <= FCS_RD_ARRAY; // RULE25
              `FCS_CMD_READ_STATUS: rmode_reg <= FCS_RD_STATUS; // RULE21
              `FCS_CMD_READ_LOCK:   rmode_reg <= FCS_RD_LOCK; // RULE15
              `FCS_CMD_CLEAR_STATUS:
              begin
                efail_reg <= 1'b0; // RULE22
                pfail_reg <= 1'b0;
                ovp_reg   <= 1'b0;
              end
              `FCS_CMD_PAGE_PROGRAM:
              begin
                if (!err_any)
                begin
                  state_reg <= FCS_LOAD_PAGE; // RULE20
                  pcnt_reg  <= 8'h00;
                end
              end
              `FCS_CMD_BLOCK_ERASE, `FCS_CMD_ERASE_ALL, `FCS_CMD_LOCK_PROGRAM:
              begin
                if (!err_any)
                begin
                  state_reg <= FCS_WAIT_CONFIRM;
                  pend_reg  <= (cmd == `FCS_CMD_BLOCK_ERASE) ? FCS_PEND_ERASE :
                               (cmd == `FCS_CMD_ERASE_ALL) ? FCS_PEND_ALL : FCS_PEND_LOCK;
                end
              end
              default: ; // RULE24
            endcase
          end
        end
        // Second cycle: only the confirm code starts work, FF backs out
        FCS_WAIT_CONFIRM:
        begin
          if (i_wr)
          begin
            state_reg <= FCS_IDLE;
            if (cmd == `FCS_CMD_READ_ARRAY)
            begin
              rmode_reg <= FCS_RD_ARRAY; // RULE23
            end
            else if (cmd != `FCS_CMD_CONFIRM)
            begin
              efail_reg <= 1'b1; // RULE23
              pfail_reg <= 1'b1;
            end
            else if (pend_reg == FCS_PEND_LOCK)
            begin
              lock_reg[ablk] <= 1'b0; // RULE14
            end
            else if (pend_reg == FCS_PEND_ERASE && blk_locked)
            begin
              efail_reg <= 1'b1; // RULE18
              pfail_reg <= 1'b1;
              rmode_reg <= FCS_RD_STATUS;
            end
            else
            begin
              state_reg <= FCS_ERASE; // RULE9 RULE12
              rmode_reg <= FCS_RD_STATUS; // RULE10
              ready_reg <= 1'b0; // RULE10
              eall_reg  <= (pend_reg == FCS_PEND_ALL);
              eblk_reg  <= (pend_reg == FCS_PEND_ALL) ? 4'h0 : {1'b0, ablk};
              tcnt_reg  <= 16'h0000;
            end
          end
        end
        // Page data: whole words, the upper byte is data here
        FCS_LOAD_PAGE:
        begin
          if (i_wr)
          begin
            pcnt_reg  <= pcnt_reg + 8'h01;
            pbase_reg <= {waddr[11:7], 7'h00};
            pblk_reg  <= {1'b0, ablk};
            if (pcnt_reg == `FCS_PAGE_WORDS - 8'h01)
            begin
              rmode_reg <= FCS_RD_STATUS; // RULE10
              tcnt_reg  <= 16'h0000;
              if (blk_locked)
              begin
                state_reg <= FCS_IDLE;
                efail_reg <= 1'b1; // RULE18
                pfail_reg <= 1'b1;
              end
              else
              begin
                state_reg <= FCS_PROG;
                ready_reg <= 1'b0; // RULE5
              end
            end
          end
        end
        // Program: copy the page into the store, then wait out the verify time
        FCS_PROG:
        begin
          tcnt_reg <= tcnt_reg + 16'h0001;
          if (tcnt_reg == `FCS_PROG_CYCLES + 16'(`FCS_PAGE_WORDS))
          begin
            state_reg <= FCS_IDLE;
            ready_reg <= 1'b1; // RULE5
          end
        end
        // Erase: fill a whole block with ones; erase-all walks every block
        FCS_ERASE:
        begin
          tcnt_reg <= tcnt_reg + 16'h0001;
          if (tcnt_reg == 16'(`FCS_BLOCK_WORDS))
          begin
            if (eblk_go)
            begin
              lock_reg[eblk_reg[2:0]] <= 1'b1; // RULE17
            end
            tcnt_reg <= 16'h0000;
            if (eall_reg && eblk_reg != 4'(`FCS_NUM_BLOCKS - 1))
            begin
              eblk_reg <= eblk_reg + 4'h1; // RULE12
            end
            else
            begin
              state_reg <= FCS_IDLE;
              ready_reg <= 1'b1; // RULE10
            end
          end
        end
        default: state_reg <= FCS_IDLE;
      endcase
    end
  end

  // Read pending marker for the registered read path
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      rd_d_reg <= 1'b0;
    end
    else
    begin
      rd_d_reg <= i_rd;
    end
  end

  // Read data: status or lock bit, held only one cycle
  // Array-mode reads give zero: the store's registered word lands a cycle late
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= 16'h0000;
    end
    else if (i_rd)
    begin
      unique case (rmode_reg)
        FCS_RD_STATUS: o_rdata <= {8'h00, ready_reg, 1'b0, efail_reg, pfail_reg, ovp_reg, 3'h0}; // RULE21
        FCS_RD_LOCK:   o_rdata <= 16'(lock_reg[ablk]) << `FCS_LOCK_DATA_POS; // RULE15
        default:       o_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      o_rdata <= 16'h0000;
    end
  end

  // Status and ready flag mirror the engine
  always_ff @(posedge i_ref_clk)
  begin
    if (clr)
    begin
      o_status          <= `FCS_STATUS_RESET;
      o_ready_busy_flag <= 1'b1;
    end
    else
    begin
      o_status          <= {ready_reg, 1'b0, efail_reg, pfail_reg, ovp_reg, 3'h0};
      o_ready_busy_flag <= ready_reg; // RULE5
    end
  end
endmodule // fcs_flash_seq
`default_nettype wire

// ===== fcs_flash_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the sequencer
module fcs_flash_seq_chk
(
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  input wire logic        i_flash_reset,
  input wire logic        i_lock_override,
  input wire logic [12:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [7:0]  o_status,
  input wire logic        o_ready_busy_flag
);
  logic [7:0]  pend_reg; // Two-cycle code awaiting its second write
  logic [12:0] busy_reg; // Cycles spent busy so far
  wire  [7:0]  cmd = i_wdata[7:0];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // Only codes taken while ready and error free open a pending command
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_flash_reset || i_wr)
      pend_reg <= (!i_srst && !i_flash_reset && pend_reg == 8'h00 && o_ready_busy_flag &&
                   o_status[5:3] == 3'h0 && cmd inside {8'h20, 8'ha7, 8'h77}) ? cmd : 8'h00;
  end
  // Counter instead of a long repetition, which the tools unroll
  always_ff @(posedge i_ref_clk)
  begin
    busy_reg <= (i_srst || o_ready_busy_flag) ? 13'h0000 : busy_reg + 13'h0001;
  end
  sequence s_status_cmd;
    i_wr && cmd == 8'h70 ##[1:2] i_rd;
  endsequence
  sequence s_erase_go;
    pend_reg inside {8'h20, 8'ha7} && i_wr && cmd == 8'hd0 && i_lock_override;
  endsequence
  a_flag_tracks_ready: assert property (o_ready_busy_flag == o_status[7])
    else $error("ready flag differs from status ready bit");
  a_status_read_data: assert property (s_status_cmd |=> o_rdata[7:0] == $past(o_status))
    else $error("status read returned wrong byte");
  a_erase_goes_busy: assert property (s_erase_go |-> ##2 !o_ready_busy_flag)
    else $error("erase did not go busy");
  a_busy_ends_bounded: assert property (busy_reg < 13'h1100)
    else $error("busy lasted too long");
  a_bad_confirm_fails: assert property (pend_reg != 8'h00 && i_wr && !(cmd inside {8'hd0, 8'hff})
    |-> ##[1:2] o_status[5:4] == 2'b11)
    else $error("bad confirm did not set failures");
  a_clear_err_bits: assert property (pend_reg == 8'h00 && i_wr && cmd == 8'h50 && o_ready_busy_flag
    |-> ##[1:2] o_status[5:3] == 3'h0)
    else $error("error bits not cleared");
  a_unknown_code_kept: assert property (pend_reg == 8'h00 && i_wr && cmd == 8'h33 && o_ready_busy_flag
    |=> ($stable(o_status))[*2])
    else $error("unknown code changed status");
  a_reset_out_values: assert property ($fell(i_srst) |-> o_status == 8'h80 && o_ready_busy_flag)
    else $error("wrong values after reset");
  a_flash_reset_ready: assert property (i_flash_reset |-> ##[1:2] o_ready_busy_flag)
    else $error("flash reset left engine busy");
endmodule // fcs_flash_seq_chk
bind fcs_flash_seq fcs_flash_seq_chk u_fcs_flash_seq_chk (.i_ref_clk, .i_srst, .i_flash_reset,
  .i_lock_override, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_status, .o_ready_busy_flag);
`default_nettype wire

// ===== fcs_map.svh
// Overview of operation
// RULE1: Commands decode low byte; page data full word
// RULE2: CPU writes commands to even array addresses
// RULE3: CPU supplies 128 words, offsets 00 to FE
// RULE4: CPU gives block top address in cycle two
// RULE5: Ready/busy flag mirrors engine ready bit
// RULE6: CPU waits for ready before next command
// RULE7: CPU stays off flash while engine busy
// RULE8: CPU never reprograms a page before erase
// RULE9: 20 then D0 at top erases block
// RULE10: Erase start enters status mode, clears ready
// RULE11: Status mode held until FF, 71 or reset
// RULE12: A7 then D0 erases blocks in turn
// RULE13: Erase all skips locked blocks unless overridden
// RULE14: 77 then D0 at top locks block
// RULE15: After 71, read top gives lock on D6
// RULE16: Locked block refuses erase and program
// RULE17: Override unlocks all; erase resets lock bit
// RULE18: Locked attempt sets erase and program failure
// RULE19: CPU checks lock or sets override first
// RULE20: 41 plus 128 words loads and programs page
// RULE21: 70 makes next read return status
// RULE22: 50 clears the three error bits
// RULE23: Bad confirm sets failures; FF cancels to array
// RULE24: Unknown command code is ignored entirely
// RULE25: Array mode reads return array word; the sequencer returns zero for them
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
`define FCS_CMD_READ_ARRAY   8'hff
`define FCS_CMD_READ_STATUS  8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PAGE_PROGRAM 8'h41
`define FCS_CMD_BLOCK_ERASE  8'h20
`define FCS_CMD_ERASE_ALL    8'ha7
`define FCS_CMD_LOCK_PROGRAM 8'h77
`define FCS_CMD_READ_LOCK    8'h71
`define FCS_CMD_CONFIRM      8'hd0
`define FCS_PAGE_WORDS       8'h80
`define FCS_SR_READY_POS     7
`define FCS_SR_ERASE_FAIL    5
`define FCS_SR_PROG_FAIL     4
`define FCS_SR_OVERPROG      3
`define FCS_LOCK_DATA_POS    6
`define FCS_STATUS_RESET     8'h80
`define FCS_ADDR_W           12
`define FCS_BLOCK_SHIFT      9
`define FCS_NUM_BLOCKS       8
`define FCS_BLOCK_WORDS      10'h200
`define FCS_PROG_CYCLES      16'h0040
`endif

// ===== fcs_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
// Port between sequencer and the array store
interface fcs_mem_if;
  logic        we;     // Word write strobe
  logic [11:0] waddr;  // Word write address
  logic [15:0] wdata;  // Word write data
  logic [11:0] raddr;  // Word read address
  logic [15:0] rdata;  // Registered read data
  modport seq (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ===== fcs_pkg.sv
package fcs_pkg;
  // Read source selected for the next array-space read
  typedef enum logic [1:0] {FCS_RD_ARRAY, FCS_RD_STATUS, FCS_RD_LOCK} fcs_read_mode_t;
  // Command sequencer phase
  typedef enum logic [2:0] {FCS_IDLE, FCS_WAIT_CONFIRM, FCS_LOAD_PAGE, FCS_PROG, FCS_ERASE} fcs_state_t;
  // Which two-cycle command awaits confirm
  typedef enum logic [1:0] {FCS_PEND_ERASE, FCS_PEND_ALL, FCS_PEND_LOCK} fcs_pend_t;
endpackage

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        flash_reset = 1'b0;
  logic        lock_override = 1'b0;
  logic [12:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [7:0]  status;
  logic        ready;
  logic [15:0] got;
  logic        ok;
  int          fails = 0;
  int          checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  fcs_flash_seq u_fcs_flash_seq (.i_ref_clk(ref_clk), .i_srst(srst), .i_flash_reset(flash_reset),
    .i_lock_override(lock_override), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_status(status), .o_ready_busy_flag(ready));
  fcs_cpu_model u_fcs_cpu_model (.i_ref_clk(ref_clk), .i_rdata(rdata), .i_ready(ready),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [12:0] top(input int b);
    return {b[2:0], 10'h3fe};
  endfunction
  // Status read; upper byte of the code is junk on purpose
  task automatic sts(input logic [7:0] want);
    u_fcs_cpu_model.put(13'h0000, 16'ha570);
    u_fcs_cpu_model.get(13'h0000, got);
    check({8'h00, got[7:0]}, {8'h00, want});
  endtask
  task automatic lockq(input int b, input logic want);
    u_fcs_cpu_model.put(top(b), 16'h0071);
    u_fcs_cpu_model.get(top(b), got);
    check(got & 16'h0040, {9'h000, want, 6'h00});
  endtask
  task automatic two(input logic [7:0] c1, input int b, input logic [7:0] c2);
    u_fcs_cpu_model.put(top(b), {8'h00, c1});
    u_fcs_cpu_model.put(top(b), {8'h00, c2});
  endtask
  task automatic settle;
    // Busy shows two edges after the start, so look only once it can
    repeat (2) @(posedge ref_clk);
    u_fcs_cpu_model.wait_ready(ok);
    check({15'h0000, ok}, 16'h0001);
  endtask
  task automatic t_basic;
    check({7'h00, ready, status}, 16'h0180);
    sts(8'h80);
    $display("test basic done");
  endtask
  task automatic t_errors;
    two(8'h20, 1, 8'h12);
    sts(8'hb0);
    u_fcs_cpu_model.put(13'h0000, 16'h0033);
    sts(8'hb0);
    u_fcs_cpu_model.put(13'h0000, 16'h0050);
    sts(8'h80);
    two(8'h20, 1, 8'hff);
    u_fcs_cpu_model.get(13'h0000, got);
    check(got, 16'h0000);
    repeat (3) @(posedge ref_clk);
    sts(8'h80);
    $display("test errors done");
  endtask
  task automatic t_lock;
    two(8'h77, 1, 8'hd0);
    lockq(1, 1'b0);
    lockq(2, 1'b1);
    two(8'h20, 1, 8'hd0);
    settle();
    sts(8'hb0);
    u_fcs_cpu_model.put(13'h0000, 16'h0050);
    u_fcs_cpu_model.page(13'h0400);
    settle();
    sts(8'hb0);
    u_fcs_cpu_model.put(13'h0000, 16'h0050);
    $display("test lock done");
  endtask
  task automatic t_erase;
    @(posedge ref_clk) lock_override <= 1'b1;
    two(8'h20, 1, 8'hd0);
    repeat (3) @(posedge ref_clk);
    #1 check({7'h00, ready, status}, 16'h0000);
    settle();
    u_fcs_cpu_model.get(13'h0000, got);
    check({8'h00, got[7:0]}, 16'h0080);
    lockq(1, 1'b1);
    $display("test erase done");
  endtask
  task automatic t_all;
    @(posedge ref_clk) lock_override <= 1'b0;
    two(8'h77, 3, 8'hd0);
    two(8'ha7, 0, 8'hd0);
    settle();
    sts(8'h80);
    lockq(3, 1'b0);
    @(posedge ref_clk) lock_override <= 1'b1;
    two(8'ha7, 0, 8'hd0);
    settle();
    lockq(3, 1'b1);
    $display("test erase all done");
  endtask
  task automatic t_page;
    u_fcs_cpu_model.page(13'h0800);
    settle();
    sts(8'h80);
    u_fcs_cpu_model.page(13'h0900);
    repeat (10) @(posedge ref_clk);
    flash_reset <= 1'b1;
    @(posedge ref_clk) flash_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check({15'h0000, ready}, 16'h0001);
    $display("test page done");
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1 t_basic();
    t_errors();
    t_lock();
    t_erase();
    t_all();
    t_page();
    close_out();
  end
  // Whole run needs about 10000 cycles; the limit allows four times that
  initial
  begin
    #400000;
    fails++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
